//--- design/ttsb_device_end.sv
// Device end of the segmented transmit bus: delimiting, flow and error checks
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Start flag high only on first transfer
// - End flag high only on last transfer
// - Start and end flags taken only when enabled
// - Error flag taken only with enable and end, or forced on segment 0 during under-run
// - Errored end replaces word with error code
// - Errored packet disables frame check only itself
// - Each segment carries four-bit empty count
// - Empty count taken only with enable and end
// - Errored end forces empty low bits to zero
// - Four independent segments numbered zero to three
// - Data word captured on every enabled cycle except an errored end
// - User stops within four cycles of not-ready
// - Overflow flagged on violation, needs reset
// - Underflow flagged, error words while under-run
module ttsb_device_end (
  input wire logic mclk,
  input wire logic rst,
  ttsb_if.dev bus,
  input wire logic line_ready,
  output logic [ttsb_pkg::SEG_COUNT-1:0] line_valid,
  output logic [ttsb_pkg::SEG_COUNT-1:0] line_first,
  output logic [ttsb_pkg::SEG_COUNT-1:0] line_last,
  output logic [ttsb_pkg::SEG_COUNT-1:0] line_bad,
  output ttsb_pkg::ttsb_empty_t line_empty,
  output ttsb_pkg::ttsb_word_t line_word,
  output logic [ttsb_pkg::SEG_COUNT-1:0] line_fcs_en,
  output logic overflow_seen,
  output logic underflow_seen
);
  import ttsb_pkg::*;

  // Flow control state
  logic ready_reg; // Ready shown to the user
  logic [3:0] stop_cnt_reg; // Cycles since ready fell
  logic [3:0] stop_cnt_next; // Next stop count
  logic overflow_reg; // Sticky overflow
  logic underflow_reg; // Under-run in progress
  // Packet tracking and beat summary
  logic pkt_open_reg; // Packet started, not yet ended
  logic pkt_open_next; // Next open state
  logic any_valid; // Some segment enabled
  logic any_first; // Some enabled start
  logic any_last; // Some enabled end
  logic first_after_last; // Start follows end in this beat
  logic unf_now; // Under-run condition this cycle

  // Beat summary over the four segments
  always_comb begin
    any_valid = |bus.valid;
    any_first = |(bus.valid & bus.first);
    any_last = |(bus.valid & bus.last);
    first_after_last = 1'b0;
    // Start above an end in segment order opens a new packet
    for (int i = 0; i < SEG_COUNT; i++) begin
      if (bus.valid[i] && bus.first[i] && any_last) begin
        // Look for an enabled end below this start
        for (int j = 0; j < i; j++) begin
          if (bus.valid[j] && bus.last[j]) begin
            first_after_last = 1'b1;
          end
        end
      end
    end
  end

  // Packet open tracking across beats
  always_comb begin
    pkt_open_next = pkt_open_reg;
    if (any_first && any_last) begin
      // Start and end in one beat: segment order decides
      pkt_open_next = first_after_last;
    end else if (any_first) begin
      // A lone start opens the packet
      pkt_open_next = 1'b1;
    end else if (any_last) begin
      // A lone end closes it
      pkt_open_next = 1'b0;
    end
  end

  // Open state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      pkt_open_reg <= 1'b0;
    end else begin
      pkt_open_reg <= pkt_open_next;
    end
  end

  // Ready follows the line side
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Not ready while the path is in reset
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= line_ready;
    end
  end

  // Count cycles of not-ready, saturating at the limit
  always_comb begin
    // Ready high keeps the count at zero
    stop_cnt_next = '0;
    if (!ready_reg) begin
      if (stop_cnt_reg < READY_STOP_CYCLES) begin
        // Still inside the allowed tail
        stop_cnt_next = stop_cnt_reg + STOP_CNT_ONE;
      end else begin
        // Hold at the limit until ready returns
        stop_cnt_next = stop_cnt_reg;
      end
    end
  end

  // Stop count register
  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_cnt_reg <= '0;
    end else begin
      stop_cnt_reg <= stop_cnt_next;
    end
  end

  // The window is counted on the ready the user sees, so the allowed
  // tail lines up with the user's own view of back-pressure
  // Overflow sticks until the path is reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else if (any_valid && !ready_reg && stop_cnt_reg >= READY_STOP_CYCLES) begin
      // Enabled data after the allowed tail
      overflow_reg <= 1'b1;
    end
  end

  // Judged only while ready is high: a user held off by the line
  // is not starving it
  // Under-run: open packet, ready, and no segment enabled
  always_comb begin
    unf_now = pkt_open_reg & ready_reg & ~any_valid;
  end

  // Underflow lasts as long as the under-run
  always_ff @(posedge mclk) begin
    if (rst) begin
      underflow_reg <= 1'b0;
    end else begin
      // Follows the condition with no memory
      underflow_reg <= unf_now;
    end
  end

  // Overflow copy for the user side of this end
  always_ff @(posedge mclk) begin
    if (rst) begin
      overflow_seen <= 1'b0;
    end else begin
      overflow_seen <= overflow_reg;
    end
  end

  // Underflow history, kept until reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      underflow_seen <= 1'b0;
    end else if (underflow_reg) begin
      // Set on any under-run, never cleared here
      underflow_seen <= 1'b1;
    end
  end

  // Handshake outputs on the bus
  assign bus.ready = ready_reg;
  assign bus.overflow = overflow_reg;
  assign bus.underflow = underflow_reg;

  // One sampler per segment, segment 0 carries the under-run error words
  generate
    for (genvar g = 0; g < SEG_COUNT; g++) begin : g_seg
      // Enable, flags, count and word of one segment
      ttsb_seg_sampler u_seg (
        .mclk(mclk),
        .rst(rst),
        .seg_valid(bus.valid[g]),
        .seg_first(bus.first[g]),
        .seg_last(bus.last[g]),
        .seg_bad(bus.bad[g]),
        .seg_empty(bus.empty[g]),
        .seg_word(bus.word[g]),
        .force_err((g == 0) ? unf_now : 1'b0),
        .out_valid(line_valid[g]),
        .out_first(line_first[g]),
        .out_last(line_last[g]),
        .out_bad(line_bad[g]),
        .out_empty(line_empty[g]),
        .out_word(line_word[g]),
        .out_fcs_en(line_fcs_en[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/ttsb_pkg.sv
// Shared constants and types for the segmented transmit bus delimiting block
package ttsb_pkg;
  // Segment geometry
  localparam int SEG_COUNT = 4;
  localparam int WORD_W = 128;
  localparam int EMPTY_W = 4;
  localparam int EMPTY_LOW_W = 3;
  localparam int CNT_W = 16;
  // Cycles the user may keep sending after ready falls
  localparam logic [3:0] READY_STOP_CYCLES = 4'h4;
  localparam logic [3:0] STOP_CNT_ONE = 4'h1;
  // Error code control word, error octet repeated over the data word
  localparam logic [WORD_W-1:0] ERR_CTRL_WORD = {16{8'hFE}};
  localparam logic [EMPTY_LOW_W-1:0] EMPTY_LOW_CLEAR = 3'h0;
  localparam logic [CNT_W-1:0] SEGS_PER_BEAT = 16'h0004;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // Per-segment bundles
  typedef logic [SEG_COUNT-1:0] ttsb_flags_t;
  typedef logic [SEG_COUNT-1:0][EMPTY_W-1:0] ttsb_empty_t;
  typedef logic [SEG_COUNT-1:0][WORD_W-1:0] ttsb_word_t;
  // User end sequencer states
  typedef enum logic [0:0] {
    TTSB_IDLE = 1'b0,
    TTSB_SEND = 1'b1
  } ttsb_state_t;
endpackage

//--- design/ttsb_if.sv
// Segmented transmit bus between user logic and the device end
`timescale 1ns/1ps
`default_nettype none
interface ttsb_if;
  import ttsb_pkg::*;
  ttsb_flags_t valid; // Segment enables
  ttsb_flags_t first; // Start of packet per segment
  ttsb_flags_t last; // End of packet per segment
  ttsb_flags_t bad; // Errored packet per segment
  ttsb_empty_t empty; // Invalid bytes on final transfer
  ttsb_word_t word; // Segment data words
  logic ready; // Device can accept data
  logic overflow; // Back-pressure violated
  logic underflow; // Packet under-run
  // Device end
  modport dev (
    input valid, first, last, bad, empty, word,
    output ready, overflow, underflow
  );
  // User logic end
  modport usr (
    output valid, first, last, bad, empty, word,
    input ready, overflow, underflow
  );
endinterface
`default_nettype wire

//--- design/ttsb_seg_sampler.sv
// One segment of the device end: qualified sampling and error substitution
`timescale 1ns/1ps
`default_nettype none
module ttsb_seg_sampler (
  input wire logic mclk,
  input wire logic rst,
  input wire logic seg_valid,
  input wire logic seg_first,
  input wire logic seg_last,
  input wire logic seg_bad,
  input wire logic [ttsb_pkg::EMPTY_W-1:0] seg_empty,
  input wire logic [ttsb_pkg::WORD_W-1:0] seg_word,
  input wire logic force_err,
  output logic out_valid,
  output logic out_first,
  output logic out_last,
  output logic out_bad,
  output logic [ttsb_pkg::EMPTY_W-1:0] out_empty,
  output logic [ttsb_pkg::WORD_W-1:0] out_word,
  output logic out_fcs_en
);
  import ttsb_pkg::*;

  logic end_seen; // Enabled end of packet
  logic bad_end; // Enabled errored end
  logic [EMPTY_W-1:0] empty_used; // Empty count as applied

  // Qualify the flags by the enable and the end flag
  always_comb begin
    end_seen = seg_valid & seg_last;
    bad_end = end_seen & seg_bad;
    empty_used = seg_empty;
    if (bad_end) begin
      empty_used[EMPTY_LOW_W-1:0] = EMPTY_LOW_CLEAR;
    end
  end

  // Delimiter flags, only taken with the enable; valid and error flag also set by a forced error
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_last <= 1'b0;
      out_bad <= 1'b0;
    end else begin
      out_valid <= seg_valid | force_err;
      out_first <= seg_valid & seg_first;
      out_last <= end_seen;
      out_bad <= bad_end | force_err;
    end
  end

  // Data word and empty count
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_word <= '0;
      out_empty <= '0;
    end else begin
      if (bad_end || force_err) begin
        out_word <= ERR_CTRL_WORD;
      end else if (seg_valid) begin
        out_word <= seg_word;
      end
      // Empty count only on an enabled end
      out_empty <= end_seen ? empty_used : '0;
    end
  end

  // Frame check off for an errored packet only
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_fcs_en <= 1'b1;
    end else begin
      out_fcs_en <= ~(bad_end | force_err);
    end
  end
endmodule
`default_nettype wire

//--- design/ttsb_user_end.sv
// User end of the segmented transmit bus: splits packets over four segments
`timescale 1ns/1ps
`default_nettype none
module ttsb_user_end (
  input wire logic mclk,
  input wire logic rst,
  ttsb_if.usr bus,
  input wire logic pkt_start,
  input wire logic [ttsb_pkg::CNT_W-1:0] pkt_words,
  input wire logic [ttsb_pkg::EMPTY_W-1:0] pkt_empty,
  input wire logic pkt_bad,
  output logic pkt_busy,
  output logic pkt_done,
  output logic link_fault
);
  import ttsb_pkg::*;

  ttsb_state_t state_reg; // Sequencer state
  logic [CNT_W-1:0] remain_reg; // Words left to send
  logic [CNT_W-1:0] seq_reg; // Payload sequence number
  logic first_pend_reg; // Start not yet sent
  logic [EMPTY_W-1:0] empty_reg; // Empty count of this packet
  logic bad_reg; // Packet is to be errored
  logic beat_go; // Send a beat this cycle
  logic final_beat; // This beat carries the end

  // Beat only while ready, so stopping is immediate
  always_comb begin
    beat_go = (state_reg == TTSB_SEND) && bus.ready;
    final_beat = remain_reg <= SEGS_PER_BEAT;
  end

  // Sequencer and word count
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= TTSB_IDLE;
      remain_reg <= CNT_ZERO;
      first_pend_reg <= 1'b0;
      empty_reg <= '0;
      bad_reg <= 1'b0;
    end else begin
      case (state_reg)
        TTSB_IDLE: begin
          // New packet only after the previous end
          if (pkt_start && pkt_words != CNT_ZERO) begin
            state_reg <= TTSB_SEND;
            remain_reg <= pkt_words;
            first_pend_reg <= 1'b1;
            empty_reg <= pkt_empty;
            bad_reg <= pkt_bad;
          end
        end
        TTSB_SEND: begin
          if (beat_go) begin
            first_pend_reg <= 1'b0;
            if (final_beat) begin
              state_reg <= TTSB_IDLE;
              remain_reg <= CNT_ZERO;
            end else begin
              remain_reg <= remain_reg - SEGS_PER_BEAT;
            end
          end
        end
        default: begin
          state_reg <= TTSB_IDLE;
        end
      endcase
    end
  end

  // Payload sequence advances one per word sent
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_reg <= CNT_ZERO;
    end else if (beat_go) begin
      seq_reg <= seq_reg + (final_beat ? remain_reg : SEGS_PER_BEAT);
    end
  end

  // Segment outputs, filled from segment 0 upward
  generate
    for (genvar g = 0; g < SEG_COUNT; g++) begin : g_seg
      logic [CNT_W-1:0] idx; // Segment index at counter width
      assign idx = CNT_W'(g);
      always_ff @(posedge mclk) begin
        if (rst) begin
          bus.valid[g] <= 1'b0;
          bus.first[g] <= 1'b0;
          bus.last[g] <= 1'b0;
          bus.bad[g] <= 1'b0;
          bus.empty[g] <= '0;
          bus.word[g] <= '0;
        end else if (beat_go && idx < remain_reg) begin
          bus.valid[g] <= 1'b1;
          bus.first[g] <= (g == 0) && first_pend_reg;
          bus.last[g] <= final_beat && (idx == remain_reg - CNT_ONE);
          bus.bad[g] <= final_beat && (idx == remain_reg - CNT_ONE) && bad_reg;
          bus.empty[g] <= (final_beat && idx == remain_reg - CNT_ONE) ? empty_reg : '0;
          bus.word[g] <= {(WORD_W / CNT_W){seq_reg + idx}};
        end else begin
          bus.valid[g] <= 1'b0;
          bus.first[g] <= 1'b0;
          bus.last[g] <= 1'b0;
          bus.bad[g] <= 1'b0;
          bus.empty[g] <= '0;
        end
      end
    end
  endgenerate

  // Status toward the user side
  always_ff @(posedge mclk) begin
    if (rst) begin
      pkt_busy <= 1'b0;
      pkt_done <= 1'b0;
      link_fault <= 1'b0;
    end else begin
      pkt_busy <= (state_reg == TTSB_SEND) && !(beat_go && final_beat);
      pkt_done <= beat_go && final_beat;
      link_fault <= link_fault | bus.overflow | bus.underflow;
    end
  end
endmodule
`default_nettype wire

//--- verification/ttsb_bus_asserts.sv
// Concurrent checks beside the segmented transmit bus
`timescale 1ns/1ps
`default_nettype none
module ttsb_bus_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire ttsb_pkg::ttsb_flags_t valid,
  input wire ttsb_pkg::ttsb_flags_t first,
  input wire ttsb_pkg::ttsb_flags_t last,
  input wire ttsb_pkg::ttsb_flags_t bad,
  input wire ttsb_pkg::ttsb_empty_t empty,
  input wire ttsb_pkg::ttsb_word_t word,
  input wire logic ready,
  input wire logic line_ready,
  input wire ttsb_pkg::ttsb_flags_t line_first,
  input wire ttsb_pkg::ttsb_flags_t line_last,
  input wire ttsb_pkg::ttsb_flags_t line_bad,
  input wire ttsb_pkg::ttsb_empty_t line_empty,
  input wire ttsb_pkg::ttsb_word_t line_word,
  input wire ttsb_pkg::ttsb_flags_t line_fcs_en
);
  import ttsb_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Enabled end on segment 0, then its errored form
  sequence s_end0;
    valid[0] && last[0];
  endsequence
  sequence s_bad_end0;
    s_end0 ##0 bad[0];
  endsequence
  a_ready_follows_line: assert property (!$past(rst) |-> ready == $past(line_ready))
    else $error("ready not one cycle behind line_ready");
  a_first_echo: assert property (line_first == $past(valid & first))
    else $error("start flag taken outside enable");
  a_last_echo: assert property (line_last == $past(valid & last))
    else $error("end flag taken outside enable");
  a_bad_gate: assert property (line_bad == $past(valid & last & bad))
    else $error("error flag taken without enable and end");
  a_fcs_per_packet: assert property (line_fcs_en == ~$past(valid & last & bad))
    else $error("frame check enable wrong");
  a_err_word_sub: assert property (s_bad_end0 |=> line_word[0] == ERR_CTRL_WORD)
    else $error("errored end not replaced by error word");
  a_empty_low_clear: assert property (s_bad_end0 |=>
    line_empty[0] == {$past(empty[0][3]), EMPTY_LOW_CLEAR}) else $error("empty low bits kept");
  a_empty_on_end: assert property (s_end0 ##0 !bad[0] |=> line_empty[0] == $past(empty[0]))
    else $error("empty count lost on end");
  a_empty_idle: assert property (!(valid[1] && last[1]) |=> line_empty[1] == 4'h0)
    else $error("empty count taken off end");
  a_word_capture: assert property (valid[1] |=> line_word[1] == $past(word[1]))
    else $error("enabled word not captured");
endmodule
`default_nettype wire

//--- verification/tb_tx_segmented_bus_packet_delimiting.sv
// Testbench joining both ends, plus a bench-driven second device end
`timescale 1ns/1ps
`default_nettype none
module tb_tx_segmented_bus_packet_delimiting;
  import ttsb_pkg::*;
  logic mclk = 1'b0; // Core clock
  logic rst = 1'b1; // Sync reset
  logic line_ready = 1'b1; // Downstream accept
  logic pkt_start = 1'b0;
  logic [CNT_W-1:0] pkt_words = CNT_ZERO;
  logic [EMPTY_W-1:0] pkt_empty = 4'h0;
  logic pkt_bad = 1'b0;
  ttsb_flags_t a_val, a_fst, a_lst, a_bad, a_fcs, b_val, b_fst, b_lst, b_bad, b_fcs;
  ttsb_empty_t a_emp, b_emp;
  ttsb_word_t a_wrd, b_wrd;
  logic b_ovs, b_uns, fault;
  logic usr_busy, usr_done; // User end status
  int word_base = 0; // First payload sequence of next packet
  int error_cnt = 0;
  int num_checks = 0;
  ttsb_if bus_a ();
  ttsb_if bus_b ();
  always #5 mclk = ~mclk;
  ttsb_user_end u_ttsb_user_end (.mclk(mclk), .rst(rst), .bus(bus_a), .pkt_start(pkt_start),
    .pkt_words(pkt_words), .pkt_empty(pkt_empty), .pkt_bad(pkt_bad), .pkt_busy(usr_busy),
    .pkt_done(usr_done), .link_fault(fault));
  ttsb_device_end u_ttsb_device_end (.mclk(mclk), .rst(rst), .bus(bus_a),
    .line_ready(line_ready), .line_valid(a_val), .line_first(a_fst), .line_last(a_lst),
    .line_bad(a_bad), .line_empty(a_emp), .line_word(a_wrd), .line_fcs_en(a_fcs),
    .overflow_seen(), .underflow_seen());
  // Second device end, fed directly by the bench for illegal traffic
  ttsb_device_end u_ttsb_device_end_2 (.mclk(mclk), .rst(rst), .bus(bus_b),
    .line_ready(line_ready), .line_valid(b_val), .line_first(b_fst), .line_last(b_lst),
    .line_bad(b_bad), .line_empty(b_emp), .line_word(b_wrd), .line_fcs_en(b_fcs),
    .overflow_seen(b_ovs), .underflow_seen(b_uns));
  ttsb_bus_asserts u_ttsb_bus_asserts (.mclk(mclk), .rst(rst), .valid(bus_a.valid),
    .first(bus_a.first), .last(bus_a.last), .bad(bus_a.bad), .empty(bus_a.empty),
    .word(bus_a.word), .ready(bus_a.ready), .line_ready(line_ready), .line_first(a_fst),
    .line_last(a_lst), .line_bad(a_bad), .line_empty(a_emp), .line_word(a_wrd),
    .line_fcs_en(a_fcs));
  // Compare small fields
  task automatic chk4(input logic [3:0] g, input logic [3:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Compare data words
  task automatic chk128(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One packet through the user end, judged beat by beat at the device end
  task automatic run_pkt(input logic [CNT_W-1:0] n, input logic [3:0] e, input logic b);
    int seg, beats, k;
    seg = (int'(n) - 1) % 4;
    beats = (int'(n) + 3) / 4;
    k = 0;
    @(negedge mclk);
    pkt_words = n;
    pkt_empty = e;
    pkt_bad = b;
    pkt_start = 1'b1;
    @(negedge mclk);
    pkt_start = 1'b0;
    while (a_val === 4'h0 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    for (int i = 0; i < beats; i++) begin
      chk4(a_fst, (i == 0) ? 4'h1 : 4'h0);
      chk4({2'h0, usr_busy, usr_done}, {2'h0, i < beats - 2, i == beats - 2});
      if (!(b && i == beats - 1 && seg == 0)) begin
        chk128(a_wrd[0], {8{16'(word_base + SEG_COUNT * i)}});
      end
      if (i == beats - 1) begin
        chk4(a_val, 4'((2 << seg) - 1));
        chk4(a_lst, 4'(1 << seg));
        chk4(a_fcs, b ? ~4'(1 << seg) : 4'hF);
        chk4(a_emp[seg], b ? {e[3], 3'h0} : e);
        if (b) chk128(a_wrd[seg], ERR_CTRL_WORD);
      end else begin
        chk4(a_val, 4'hF);
      end
      @(negedge mclk);
    end
    chk4(a_val, 4'h0);
    chk4({3'h0, fault}, 4'h0);
    word_base += int'(n);
  endtask
  task automatic t_plain();
    run_pkt(16'h0009, 4'h5, 1'b0);
  endtask
  task automatic t_errored();
    run_pkt(16'h0005, 4'hD, 1'b1);
  endtask
  task automatic t_full_beat();
    run_pkt(16'h0004, 4'hF, 1'b0);
  endtask
  // Flags and counts outside enable or end are dropped
  task automatic t_gating();
    bus_b.first = 4'hF;
    bus_b.last = 4'hF;
    bus_b.bad = 4'hF;
    bus_b.empty = '1;
    bus_b.word = {32{16'h1234}};
    @(negedge mclk);
    chk4(b_fst | b_lst | b_bad, 4'h0);
    chk4(b_emp[2], 4'h0);
    bus_b.valid = 4'hF;
    bus_b.first = 4'h0;
    bus_b.bad = 4'h5;
    @(negedge mclk);
    chk4(b_bad, 4'h5);
    chk4(b_fcs, 4'hA);
    chk4(b_emp[0], 4'h8);
    chk4(b_emp[1], 4'hF);
    chk128(b_wrd[0], ERR_CTRL_WORD);
    chk128(b_wrd[1], {8{16'h1234}});
    bus_b.valid = 4'h4;
    bus_b.last = 4'h0;
    bus_b.word = '0;
    @(negedge mclk);
    chk4(b_bad, 4'h0);
    chk4(b_emp[2], 4'h0);
    chk128(b_wrd[2], '0);
    // Idle the bus and clear leftovers before the next scenario
    bus_b.valid = 4'h0;
    bus_b.bad = 4'h0;
    bus_b.empty = '0;
    @(negedge mclk);
  endtask
  // Open packet starved of data, then closed
  task automatic t_underrun();
    bus_b.valid = 4'h1;
    bus_b.first = 4'h1;
    @(negedge mclk);
    bus_b.valid = 4'h0;
    bus_b.first = 4'h0;
    repeat (2) @(negedge mclk);
    chk4({3'h0, bus_b.underflow}, 4'h1);
    chk4(b_val & b_bad & ~b_fcs, 4'h1);
    chk128(b_wrd[0], ERR_CTRL_WORD);
    bus_b.valid = 4'h1;
    bus_b.last = 4'h1;
    @(negedge mclk);
    bus_b.valid = 4'h0;
    bus_b.last = 4'h0;
    repeat (2) @(negedge mclk);
    chk4({2'h0, bus_b.underflow, b_uns}, 4'h1);
  endtask
  // Late stop overflows, sticky until reset
  task automatic t_overflow();
    line_ready = 1'b0;
    @(negedge mclk);
    // Full four-cycle tail after ready falls is still legal
    bus_b.valid = 4'h1;
    repeat (4) @(negedge mclk);
    bus_b.valid = 4'h0;
    repeat (5) @(negedge mclk);
    chk4({3'h0, bus_b.overflow}, 4'h0);
    chk4({3'h0, bus_b.ready}, 4'h0);
    bus_b.valid = 4'h1;
    @(negedge mclk);
    bus_b.valid = 4'h0;
    line_ready = 1'b1;
    repeat (3) @(negedge mclk);
    chk4({2'h0, bus_b.overflow, b_ovs}, 4'h3);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk4({3'h0, bus_b.overflow}, 4'h0);
  endtask
  initial begin
    bus_b.valid = '0;
    bus_b.first = '0;
    bus_b.last = '0;
    bus_b.bad = '0;
    bus_b.empty = '0;
    bus_b.word = '0;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_plain();
    t_errored();
    t_full_beat();
    t_gating();
    t_underrun();
    t_overflow();
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
